// ---- hdl/fcrs_top.sv ----
// How it works
// - Current at or above threshold means clog.
// - Feedback at or above signed threshold means clog.
// - Act only after condition holds detection time.
// - Action suspends PID, reverses, counts one event.
// - After reverse time, return forward under PID.
// - Trip mode: count spent, next detection trips.
// - Warning mode: count spent, warn and reverse.
// - Allowed count one to ten, then end action.
// - Cycle hours set: periodic reverse run.
// - Periodic run ignores clog detection.
// - Cycle due during detection run is skipped.
// - Mode codes: off, jam, clog trip, clog warn.
// - Second PID channel clears count and timers.
`timescale 1ns/100ps
`include "fcrs_defines.svh"

module fcrs_top #(
    parameter int unsigned TICK_CYCLES = `FCRS_TICK_PERIOD_NS / `FCRS_CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               arst_n,
    // Avalon-MM slave
    input  wire logic [5:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic      [31:0]        avs_readdata,
    output logic                    avs_waitrequest,
    // Drive measurements
    input  wire logic [7:0]         output_current_pct,
    input  wire logic signed [23:0] feedback_pv,
    input  wire logic               overcurrent_hit,
    input  wire logic               pid_channel2,
    // Drive commands
    output logic                    pid_suspend,
    output logic                    reverse_run,
    output logic      [10:0]        reverse_frequency,
    output logic                    clog_fault_trip,
    output logic                    jam_fault_trip,
    output logic                    clog_warning,
    output logic                    irq
);

    // Bus handshake: first edge latches read data, second edge completes.
    logic        ack_q;
    logic [31:0] rdata_q;
    wire         req     = avs_read | avs_write;
    wire         wr_en   = avs_write & ack_q;
    wire  [5:0]  addr    = {avs_address[5:2], 2'b00};
    wire  [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    assign avs_waitrequest = req & ~ack_q;
    assign avs_readdata    = rdata_q;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m,
                                          input logic [31:0] w);
        merge = (old & ~m) | (w & m);
    endfunction : merge

    // Configuration registers.
    logic [31:0] ctrl_q;
    logic [13:0] cycle_hours_q;
    logic [7:0]  cur_thr_q;
    logic [31:0] pv_thr_q;
    logic [9:0]  det_time_q;
    logic [10:0] rev_freq_q;
    logic [9:0]  rev_time_q;
    logic [3:0]  allowed_q;
    logic [2:0]  irq_sts_q;
    logic [2:0]  irq_mask_q;

    wire w_ctrl  = wr_en && addr == `FCRS_OFS_CTRL;
    wire w_cyc   = wr_en && addr == `FCRS_OFS_CYCLE_HOURS;
    wire w_cur   = wr_en && addr == `FCRS_OFS_CUR_THR;
    wire w_pv    = wr_en && addr == `FCRS_OFS_PV_THR;
    wire w_det   = wr_en && addr == `FCRS_OFS_DET_TIME;
    wire w_rfq   = wr_en && addr == `FCRS_OFS_REV_FREQ;
    wire w_rtm   = wr_en && addr == `FCRS_OFS_REV_TIME;
    wire w_alw   = wr_en && addr == `FCRS_OFS_ALLOWED;
    wire w_isr   = wr_en && addr == `FCRS_OFS_IRQ_STS;
    wire w_imk   = wr_en && addr == `FCRS_OFS_IRQ_MASK;

    wire [31:0] ctrl_w  = merge(ctrl_q, be_mask, avs_writedata);
    wire [31:0] cyc_w   = merge({18'h0_0000, cycle_hours_q}, be_mask, avs_writedata);
    wire [31:0] cur_w   = merge({24'h00_0000, cur_thr_q}, be_mask, avs_writedata);
    wire [31:0] pv_w    = merge(pv_thr_q, be_mask, avs_writedata);
    wire [31:0] det_w   = merge({22'h00_0000, det_time_q}, be_mask, avs_writedata);
    wire [31:0] rfq_w   = merge({21'h00_0000, rev_freq_q}, be_mask, avs_writedata);
    wire [31:0] rtm_w   = merge({22'h00_0000, rev_time_q}, be_mask, avs_writedata);
    wire [31:0] alw_w   = merge({28'h000_0000, allowed_q}, be_mask, avs_writedata);
    wire [31:0] imk_w   = merge({29'h0000_0000, irq_mask_q}, be_mask, avs_writedata);
    wire [2:0]  w1c     = (w_isr && avs_byteenable[0]) ? avs_writedata[2:0] : 3'h0;
    wire        flt_clr = w_ctrl && avs_byteenable[1] && avs_writedata[`FCRS_CTRL_FLT_CLR];

    // Out-of-range values are clamped on write.
    wire [7:0]  cur_clamp = (cur_w[7:0] > `FCRS_CUR_THR_MAX) ? `FCRS_CUR_THR_MAX : cur_w[7:0];
    wire [9:0]  det_clamp = (det_w[9:0] > `FCRS_DET_TIME_MAX) ? `FCRS_DET_TIME_MAX : det_w[9:0];
    wire [9:0]  rtm_clamp = (rtm_w[9:0] > `FCRS_REV_TIME_MAX) ? `FCRS_REV_TIME_MAX : rtm_w[9:0];
    wire [10:0] rfq_clamp = (rfq_w[10:0] > `FCRS_REV_FREQ_MAX) ?
                            `FCRS_REV_FREQ_MAX : rfq_w[10:0];
    wire [13:0] cyc_clamp = (cyc_w[13:0] > `FCRS_CYCLE_MAX) ? `FCRS_CYCLE_MAX : cyc_w[13:0];
    wire [3:0]  alw_clamp = (alw_w[3:0] == 4'h0) ? 4'h1 :
                            (alw_w[3:0] > `FCRS_ALLOWED_MAX) ? `FCRS_ALLOWED_MAX : alw_w[3:0];

    fcrs_pkg::fcrs_mode_t mode;
    assign mode = fcrs_pkg::fcrs_mode_t'(ctrl_q[1:0]);

    // Seconds tick and sequencer state.
    logic [26:0] presc_q;
    logic [9:0]  det_cnt_q;
    logic [9:0]  rev_cnt_q;
    logic [11:0] sec_in_hour_q;
    logic [13:0] hours_q;
    logic [3:0]  clog_count_q;
    logic        rev_by_cycle_q;
    fcrs_pkg::fcrs_state_t state_q;
    fcrs_pkg::fcrs_state_t state_d;

    wire tick      = presc_q == 27'(TICK_CYCLES - 1);
    wire in_fwd    = state_q == fcrs_pkg::FCRS_FWD;
    wire in_rev    = state_q == fcrs_pkg::FCRS_REV;
    wire active    = mode != fcrs_pkg::FCRS_OFF && !pid_channel2;

    wire cur_cond  = cur_thr_q != 8'h00 && output_current_pct >= cur_thr_q;
    wire pv_cond   = pv_thr_q[`FCRS_PV_THR_EN] &&
                     feedback_pv >= $signed(pv_thr_q[23:0]);
    wire clog_cond = ctrl_q[`FCRS_CTRL_PV_SEL] ? pv_cond : cur_cond;
    wire cond      = (mode == fcrs_pkg::FCRS_JAM_TRIP) ? overcurrent_hit : clog_cond;
    wire det_ok    = active && in_fwd && cond;
    wire fire      = det_ok && det_cnt_q >= det_time_q;
    wire spent     = clog_count_q >= allowed_q;
    wire rev_done  = in_rev && rev_cnt_q >= rev_time_q;
    wire cyc_due   = active && cycle_hours_q != 14'h0000 && hours_q >= cycle_hours_q;
    wire cyc_start = cyc_due && in_fwd && !fire;
    wire go_trip   = fire && spent && mode != fcrs_pkg::FCRS_CLOG_WARN;
    wire go_warn   = fire && spent && mode == fcrs_pkg::FCRS_CLOG_WARN;
    wire go_rev    = (fire && !go_trip) || cyc_start;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            fcrs_pkg::FCRS_FWD: begin
                if (go_trip) begin
                    state_d = fcrs_pkg::FCRS_TRIP;
                end else if (go_rev) begin
                    state_d = fcrs_pkg::FCRS_REV;
                end
            end
            fcrs_pkg::FCRS_REV: begin
                if (rev_done || !active) begin
                    state_d = fcrs_pkg::FCRS_FWD;
                end
            end
            fcrs_pkg::FCRS_TRIP: begin
                if (flt_clr) begin
                    state_d = fcrs_pkg::FCRS_FWD;
                end
            end
            default: state_d = fcrs_pkg::FCRS_FWD;
        endcase
    end

    wire [2:0] events = {go_warn, go_trip, go_rev};
    wire [9:0] det_cnt_d = (!det_ok) ? 10'h000 :
                           (tick && det_cnt_q != 10'h3FF) ? det_cnt_q + 10'h001 : det_cnt_q;
    wire [3:0] count_d = pid_channel2 || flt_clr ? 4'h0 :
                         (fire && !spent) ? clog_count_q + 4'h1 : clog_count_q;

    wire [31:0] status_word = {16'h0000, 2'b00, clog_warning, jam_fault_trip,
                               clog_fault_trip, rev_by_cycle_q, state_q, 4'h0, clog_count_q};
    wire [31:0] rd_mux =
        (addr == `FCRS_OFS_CTRL)        ? {ctrl_q[31:9], 1'b0, ctrl_q[7:0]} :
        (addr == `FCRS_OFS_CYCLE_HOURS) ? {18'h0_0000, cycle_hours_q} :
        (addr == `FCRS_OFS_CUR_THR)     ? {24'h00_0000, cur_thr_q} :
        (addr == `FCRS_OFS_PV_THR)      ? pv_thr_q :
        (addr == `FCRS_OFS_DET_TIME)    ? {22'h00_0000, det_time_q} :
        (addr == `FCRS_OFS_REV_FREQ)    ? {21'h00_0000, rev_freq_q} :
        (addr == `FCRS_OFS_REV_TIME)    ? {22'h00_0000, rev_time_q} :
        (addr == `FCRS_OFS_ALLOWED)     ? {28'h000_0000, allowed_q} :
        (addr == `FCRS_OFS_STATUS)      ? status_word :
        (addr == `FCRS_OFS_IRQ_STS)     ? {29'h0000_0000, irq_sts_q} :
        (addr == `FCRS_OFS_IRQ_MASK)    ? {29'h0000_0000, irq_mask_q} : 32'h0000_0000;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= req & ~ack_q;
            rdata_q <= (avs_read & ~ack_q) ? rd_mux : rdata_q;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q        <= 32'h0000_0000;
            cycle_hours_q <= 14'h0000;
            cur_thr_q     <= `FCRS_RST_CUR_THR;
            pv_thr_q      <= 32'h0000_0000;
            det_time_q    <= `FCRS_RST_DET_TIME;
            rev_freq_q    <= `FCRS_RST_REV_FREQ;
            rev_time_q    <= `FCRS_RST_REV_TIME;
            allowed_q     <= `FCRS_RST_ALLOWED;
            irq_mask_q    <= 3'h0;
        end else begin
            if (w_ctrl) ctrl_q <= {ctrl_w[31:9], 1'b0, ctrl_w[7:0]};
            if (w_cyc)  cycle_hours_q <= cyc_clamp;
            if (w_cur)  cur_thr_q <= cur_clamp;
            if (w_pv)   pv_thr_q <= pv_w;
            if (w_det)  det_time_q <= det_clamp;
            if (w_rfq)  rev_freq_q <= rfq_clamp;
            if (w_rtm)  rev_time_q <= rtm_clamp;
            if (w_alw)  allowed_q <= alw_clamp;
            if (w_imk)  irq_mask_q <= imk_w[2:0];
        end
    end

    // A hardware event in the same cycle as its clear keeps the bit set.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq_sts_q <= 3'h0;
        end else begin
            irq_sts_q <= (irq_sts_q & ~w1c) | events;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            presc_q   <= 27'h000_0000;
            state_q   <= fcrs_pkg::FCRS_FWD;
            det_cnt_q <= 10'h000;
            clog_count_q <= 4'h0;
        end else begin
            presc_q   <= tick ? 27'h000_0000 : presc_q + 27'h000_0001;
            state_q   <= state_d;
            det_cnt_q <= det_cnt_d;
            clog_count_q <= count_d;
        end
    end

    // Reverse run timer and periodic cycle bookkeeping.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rev_cnt_q      <= 10'h000;
            rev_by_cycle_q <= 1'b0;
        end else begin
            rev_cnt_q      <= (!in_rev || pid_channel2) ? 10'h000 :
                              tick ? rev_cnt_q + 10'h001 : rev_cnt_q;
            rev_by_cycle_q <= (state_d == fcrs_pkg::FCRS_REV) &&
                              (cyc_start || (in_rev && rev_by_cycle_q));
        end
    end

    // A cycle falling due while a detection run reverses is dropped; the hours restart.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sec_in_hour_q <= 12'h000;
            hours_q       <= 14'h0000;
        end else if (!active || cyc_due) begin
            sec_in_hour_q <= 12'h000;
            hours_q       <= 14'h0000;
        end else if (tick) begin
            sec_in_hour_q <= (sec_in_hour_q == `FCRS_SEC_PER_HOUR - 12'h001) ?
                             12'h000 : sec_in_hour_q + 12'h001;
            hours_q       <= (sec_in_hour_q == `FCRS_SEC_PER_HOUR - 12'h001) ?
                             hours_q + 14'h0001 : hours_q;
        end
    end

    // A new trip or warning in the cycle of a fault clear keeps its flag set.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            clog_fault_trip   <= 1'b0;
            jam_fault_trip    <= 1'b0;
            clog_warning      <= 1'b0;
            reverse_run       <= 1'b0;
            pid_suspend       <= 1'b0;
            reverse_frequency <= 11'h000;
        end else begin
            clog_fault_trip   <= (clog_fault_trip & ~flt_clr) |
                                 (go_trip && mode == fcrs_pkg::FCRS_CLOG_TRIP);
            jam_fault_trip    <= (jam_fault_trip & ~flt_clr) |
                                 (go_trip && mode == fcrs_pkg::FCRS_JAM_TRIP);
            clog_warning      <= (clog_warning & ~flt_clr & active) | go_warn;
            reverse_run       <= state_d == fcrs_pkg::FCRS_REV;
            pid_suspend       <= state_d != fcrs_pkg::FCRS_FWD;
            reverse_frequency <= (state_d == fcrs_pkg::FCRS_REV) ? rev_freq_q : 11'h000;
        end
    end

    assign irq = |(irq_sts_q & irq_mask_q);

    // Checks.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    cur_detect_a: assert property (!ctrl_q[`FCRS_CTRL_PV_SEL]
        && mode == fcrs_pkg::FCRS_CLOG_TRIP
        && cur_thr_q != 8'h00 && output_current_pct < cur_thr_q |-> !cond)
        else $error("current below threshold seen as clog");
    pv_detect_a: assert property (ctrl_q[`FCRS_CTRL_PV_SEL]
        && mode == fcrs_pkg::FCRS_CLOG_WARN
        && pv_thr_q[`FCRS_PV_THR_EN] && feedback_pv >= $signed(pv_thr_q[23:0]) |-> cond)
        else $error("feedback above threshold missed");
    detect_time_a: assert property (fire |-> cond
        && (det_time_q == 10'h000 || $past(det_ok)))
        else $error("action fired before detection time");
    reverse_start_a: assert property (fire && !spent |=> reverse_run && pid_suspend
        && clog_count_q == $past(clog_count_q) + 4'h1 && reverse_frequency == rev_freq_q)
        else $error("reverse run did not start correctly");
    reverse_end_a: assert property (rev_done && active |=> !reverse_run && !pid_suspend)
        else $error("reverse run did not end");
    clog_trip_a: assert property (fire && spent && mode == fcrs_pkg::FCRS_CLOG_TRIP
        |=> clog_fault_trip && !reverse_run && clog_count_q == $past(clog_count_q))
        else $error("trip mode did not trip");
    clog_warn_a: assert property (fire && spent && mode == fcrs_pkg::FCRS_CLOG_WARN
        |=> clog_warning && reverse_run && !clog_fault_trip)
        else $error("warning mode did not warn and reverse");
    count_bound_a: assert property (clog_count_q != $past(clog_count_q)
        && clog_count_q != 4'h0 |-> clog_count_q <= $past(allowed_q))
        else $error("count passed allowed value");
    jam_trip_a: assert property (fire && spent && mode == fcrs_pkg::FCRS_JAM_TRIP
        |=> jam_fault_trip && !reverse_run && !clog_warning)
        else $error("jam mode did not trip");
    cycle_run_a: assert property (cyc_start |=> rev_by_cycle_q && reverse_run)
        else $error("periodic reverse not started");
    cycle_ignore_a: assert property (rev_by_cycle_q |-> !fire && !clog_fault_trip)
        else $error("detection during periodic run");
    cycle_skip_a: assert property (cyc_due && in_rev && !rev_by_cycle_q
        |=> !rev_by_cycle_q && hours_q == 14'h0000)
        else $error("periodic cycle not skipped");
    chan_clear_a: assert property (pid_channel2
        |=> clog_count_q == 4'h0 && det_cnt_q == 10'h000)
        else $error("channel switch did not clear");
    det_restart_a: assert property (in_fwd && !cond |=> det_cnt_q == 10'h000)
        else $error("detection timer not restarted");

endmodule : fcrs_top

// ---- common/fcrs_defines.svh ----
`ifndef FCRS_DEFINES_SVH
`define FCRS_DEFINES_SVH

// Register byte offsets.
`define FCRS_OFS_CTRL        6'h00
`define FCRS_OFS_CYCLE_HOURS 6'h04
`define FCRS_OFS_CUR_THR     6'h08
`define FCRS_OFS_PV_THR      6'h0C
`define FCRS_OFS_DET_TIME    6'h10
`define FCRS_OFS_REV_FREQ    6'h14
`define FCRS_OFS_REV_TIME    6'h18
`define FCRS_OFS_ALLOWED     6'h1C
`define FCRS_OFS_STATUS      6'h20
`define FCRS_OFS_IRQ_STS     6'h24
`define FCRS_OFS_IRQ_MASK    6'h28

// Control register fields and the feedback threshold enable bit.
`define FCRS_CTRL_MODE_LSB   0
`define FCRS_CTRL_PV_SEL     4
`define FCRS_CTRL_FLT_CLR    8
`define FCRS_PV_THR_EN       31

// Interrupt bit positions.
`define FCRS_IRQ_REVERSE     0
`define FCRS_IRQ_TRIP        1
`define FCRS_IRQ_WARN        2

// Reset values.
`define FCRS_RST_CUR_THR     8'h00
`define FCRS_RST_DET_TIME    10'h000
`define FCRS_RST_REV_FREQ    11'h000
`define FCRS_RST_REV_TIME    10'h000
`define FCRS_RST_ALLOWED     4'h1

// Ranges.
`define FCRS_CUR_THR_MAX     8'h96
`define FCRS_DET_TIME_MAX    10'h258
`define FCRS_REV_TIME_MAX    10'h258
`define FCRS_REV_FREQ_MAX    11'h4B0
`define FCRS_ALLOWED_MAX     4'hA
`define FCRS_CYCLE_MAX       14'h2710

// Timing.
`define FCRS_CLK_PERIOD_NS   10
`define FCRS_TICK_PERIOD_NS  1000000000
`define FCRS_SEC_PER_HOUR    12'hE10

`endif

// ---- common/fcrs_pkg.sv ----
package fcrs_pkg;

    typedef enum logic [1:0] {
        FCRS_OFF,
        FCRS_JAM_TRIP,
        FCRS_CLOG_TRIP,
        FCRS_CLOG_WARN
    } fcrs_mode_t;

    typedef enum logic [1:0] {
        FCRS_FWD,
        FCRS_REV,
        FCRS_TRIP
    } fcrs_state_t;

endpackage : fcrs_pkg

// ---- bench/fcrs_drive_model.sv ----
`timescale 1ns/100ps
module fcrs_drive_model (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               arst_n,
    // Bench commands
    input  wire logic               cmd_clog,
    input  wire logic [7:0]         cur_clog,
    input  wire logic [7:0]         cur_norm,
    input  wire logic signed [23:0] pv_clog,
    // Drive state
    input  wire logic               reverse_run,
    input  wire logic               pid_suspend,
    // Measurements
    output logic      [7:0]         output_current_pct,
    output logic signed [23:0]      feedback_pv,
    output logic                    overcurrent_hit
);
    // Reversing or stopping sheds the load, so the clog only shows while running forward.
    wire logic fwd_load = cmd_clog & ~reverse_run & ~pid_suspend;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            output_current_pct <= 8'h00;
            feedback_pv        <= 24'h00_0000;
            overcurrent_hit    <= 1'b0;
        end else begin
            output_current_pct <= fwd_load ? cur_clog : cur_norm;
            feedback_pv        <= fwd_load ? pv_clog : 24'hFF_EC78;
            overcurrent_hit    <= fwd_load;
        end
    end
endmodule : fcrs_drive_model

// ---- bench/tb_top.sv ----
`timescale 1ns/100ps
`include "fcrs_defines.svh"
module tb_top;
    localparam int TK = 10;
    logic               clk_sys = 1'b0;
    logic               arst_n = 1'b0;
    logic [5:0]         avs_address = 6'h00;
    logic               avs_read = 1'b0;
    logic               avs_write = 1'b0;
    logic [31:0]        avs_writedata = 32'h0000_0000;
    logic [31:0]        avs_readdata;
    logic               avs_waitrequest;
    logic [7:0]         output_current_pct;
    logic signed [23:0] feedback_pv;
    logic               overcurrent_hit;
    logic               pid_channel2 = 1'b0;
    logic               pid_suspend;
    logic               reverse_run;
    logic [10:0]        reverse_frequency;
    logic               clog_fault_trip;
    logic               jam_fault_trip;
    logic               clog_warning;
    logic               irq;
    logic               cmd_clog = 1'b0;
    logic [7:0]         cur_clog = 8'h00;
    logic [7:0]         cur_norm = 8'h00;
    logic signed [23:0] pv_clog = 24'h00_0000;
    logic [31:0]        q;
    int n_fail = 0, n_checks = 0, cyc = 0, n = 0;
    int m_count = 0, m_allowed = 1, m_mode = 0, m_thr = 1;

    always #5 clk_sys = ~clk_sys;

    fcrs_top #(.TICK_CYCLES(TK)) dut (.clk_sys(clk_sys), .arst_n(arst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .output_current_pct(output_current_pct),
        .feedback_pv(feedback_pv), .overcurrent_hit(overcurrent_hit),
        .pid_channel2(pid_channel2), .pid_suspend(pid_suspend), .reverse_run(reverse_run),
        .reverse_frequency(reverse_frequency), .clog_fault_trip(clog_fault_trip),
        .jam_fault_trip(jam_fault_trip), .clog_warning(clog_warning), .irq(irq));

    fcrs_drive_model drive (.clk_sys(clk_sys), .arst_n(arst_n), .cmd_clog(cmd_clog),
        .cur_clog(cur_clog), .cur_norm(cur_norm), .pv_clog(pv_clog),
        .reverse_run(reverse_run), .pid_suspend(pid_suspend),
        .output_current_pct(output_current_pct), .feedback_pv(feedback_pv),
        .overcurrent_hit(overcurrent_hit));

    task automatic give_verdict();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, seen, exp);
        end
    endtask : check

    // Request held until the rising edge at which waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    task automatic rd(input logic [5:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0000_0000);
        check(q, exp, what);
    endtask : rd

    task automatic hold_clog(input int cycles);
        @(posedge clk_sys);
        cmd_clog <= 1'b1;
        repeat (cycles) @(posedge clk_sys);
        cmd_clog <= 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask : hold_clog

    task automatic cfg(input int mode, input logic [31:0] ctrl, input int allowed);
        m_mode    = mode;
        m_allowed = allowed;
        m_count   = 0;
        m_thr     = 1 + $urandom % 150;
        bus(1'b1, `FCRS_OFS_CUR_THR, 32'(m_thr));
        bus(1'b1, `FCRS_OFS_DET_TIME, 32'h0000_0003);
        bus(1'b1, `FCRS_OFS_REV_FREQ, 32'h0000_04B0);
        bus(1'b1, `FCRS_OFS_REV_TIME, 32'h0000_0002);
        bus(1'b1, `FCRS_OFS_ALLOWED, 32'(allowed));
        cur_clog <= 8'(m_thr);
        cur_norm <= 8'($urandom % m_thr);
        bus(1'b1, `FCRS_OFS_CTRL, ctrl);
    endtask : cfg

    // One detection: the model predicts reverse, trip or warning and the count.
    task automatic det_step();
        logic spent;
        logic exp_rev;
        logic [31:0] exp_sts;
        spent   = (m_count >= m_allowed);
        exp_rev = !spent || (m_mode == 3);
        @(posedge clk_sys);
        cmd_clog <= 1'b1;
        n = 0;
        while (!reverse_run && !clog_fault_trip && !jam_fault_trip && n < 6 * TK) begin
            @(negedge clk_sys);
            n++;
        end
        check(n >= 2 * TK && n <= 4 * TK + 4, 1'b1, "detect delay");
        check(reverse_run, exp_rev, "reverse");
        check(clog_fault_trip, spent && m_mode == 2, "clog trip");
        check(jam_fault_trip, spent && m_mode == 1, "jam trip");
        check(clog_warning, spent && m_mode == 3, "warning");
        check(pid_suspend, 1'b1, "suspend");
        if (exp_rev) begin
            check(reverse_frequency, 11'h4B0, "rev freq");
            if (!spent) m_count++;
            n = 0;
            while (reverse_run && n < 4 * TK) begin
                @(negedge clk_sys);
                n++;
            end
            check(n >= TK && n <= 2 * TK + 4, 1'b1, "rev time");
            check(pid_suspend, 1'b0, "resume pid");
        end
        exp_sts = 32'(m_count);
        if (spent && m_mode == 3) exp_sts[13] = 1'b1;
        else if (spent) exp_sts = exp_sts | 32'h0000_0200 |
                                  ((m_mode == 2) ? 32'h0000_0800 : 32'h0000_1000);
        rd(`FCRS_OFS_STATUS, exp_sts, "count");
    endtask : det_step

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            $display("MISMATCH t=%0t timeout", $time);
            give_verdict();
        end
    end

    initial begin
        void'($urandom(32'haa5f));
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(negedge clk_sys);
        check({pid_suspend, reverse_run, clog_fault_trip, irq}, 4'h0, "reset outs");
        for (int a = 0; a < 12; a++) rd(6'(4 * a), 32'(a == 7), "reset reg");
        bus(1'b1, `FCRS_OFS_ALLOWED, 32'h0000_0000);
        rd(`FCRS_OFS_ALLOWED, 32'h0000_0001, "allowed min");
        bus(1'b1, `FCRS_OFS_ALLOWED, 32'h0000_000F);
        rd(`FCRS_OFS_ALLOWED, 32'h0000_000A, "allowed max");
        bus(1'b1, 6'h30, 32'hFFFF_FFFF);
        rd(6'h30, 32'h0000_0000, "unmapped");
        bus(1'b1, `FCRS_OFS_IRQ_MASK, 32'h0000_0007);
        cfg(0, 32'h0000_0000, 1);
        hold_clog(6 * TK);
        check(reverse_run, 1'b0, "mode off");
        cfg(2, 32'h0000_0002, 2);
        cur_clog <= 8'(m_thr - 1);
        hold_clog(6 * TK);
        check(reverse_run, 1'b0, "below thr");
        cur_clog <= 8'(m_thr);
        repeat (4) hold_clog(2 * TK);
        check(reverse_run, 1'b0, "timer restart");
        repeat (3) det_step();
        cmd_clog <= 1'b0;
        rd(`FCRS_OFS_IRQ_STS, 32'h0000_0003, "irq sts");
        @(negedge clk_sys);
        check(irq, 1'b1, "irq");
        bus(1'b1, `FCRS_OFS_IRQ_STS, 32'h0000_0001);
        bus(1'b1, `FCRS_OFS_IRQ_MASK, 32'h0000_0001);
        @(negedge clk_sys);
        check(irq, 1'b0, "irq masked");
        bus(1'b1, `FCRS_OFS_IRQ_STS, 32'h0000_0002);
        rd(`FCRS_OFS_IRQ_STS, 32'h0000_0000, "irq clear");
        bus(1'b1, `FCRS_OFS_CTRL, 32'h0000_0100);
        bus(1'b1, `FCRS_OFS_PV_THR, 32'h80FF_FF9C);
        pv_clog <= 24'hFF_FF9C;
        cfg(3, 32'h0000_0013, 1);
        repeat (3) det_step();
        cmd_clog <= 1'b0;
        bus(1'b1, `FCRS_OFS_CTRL, 32'h0000_0100);
        cfg(1, 32'h0000_0001, 1);
        repeat (2) det_step();
        cmd_clog <= 1'b0;
        bus(1'b1, `FCRS_OFS_CTRL, 32'h0000_0100);
        cfg(2, 32'h0000_0002, 3);
        det_step();
        cmd_clog     <= 1'b0;
        pid_channel2 <= 1'b1;
        m_count = 0;
        rd(`FCRS_OFS_STATUS, 32'h0000_0000, "chan2 clear");
        pid_channel2 <= 1'b0;
        bus(1'b1, `FCRS_OFS_CYCLE_HOURS, 32'h0000_0001);
        n = 0;
        while (!reverse_run && n < 3610 * TK) begin
            @(negedge clk_sys);
            n++;
        end
        check(n >= 3590 * TK && n < 3610 * TK, 1'b1, "cycle time");
        bus(1'b0, `FCRS_OFS_STATUS, 32'h0000_0000);
        check(q[10], 1'b1, "periodic run");
        check(q[3:0], 4'h0, "periodic count");
        give_verdict();
    end
endmodule : tb_top
